// >>> src/sfs_seq.v
// Contract
// - opcode D8h is 64K-byte sector erase with three address bytes.
// - D7h and 20h both mean small-sector erase with three address bytes.
// - internal erase starts only on chip select rising after a valid command.
// - erase completion clears write enable automatically.
// - page program completion returns to write-disabled state.
// - status write completion drops write enable.
// - status write stays busy within 15 ms, typically 5 ms.
// - page program completes within 5.0 ms, typically 4.0 ms.
// - small-sector erase completes within 0.15 s, typically 0.04 s.
// - 64K-byte sector erase completes within 0.25 s, typically 0.08 s.
// - chip erase completes within 1.6 s, typically 0.25 s.
// - device accepts commands within 3 us after power-down release.
`timescale 1ns/1ps
`include "sfs_map.vh"

module sfs_seq #(
    parameter [31:0] SRW_CYCLES = `SFS_SRW_TIME_MS * 1000 * `SFS_CLK_MHZ,
    parameter [31:0] PP_CYCLES  = `SFS_PP_TIME_US * `SFS_CLK_MHZ,
    parameter [31:0] SSE_CYCLES = `SFS_SSE_TIME_MS * 1000 * `SFS_CLK_MHZ,
    parameter [31:0] SE_CYCLES  = `SFS_SE_TIME_MS * 1000 * `SFS_CLK_MHZ,
    parameter [31:0] CHE_CYCLES = `SFS_CHE_TIME_MS * 1000 * `SFS_CLK_MHZ
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // spi pins, sampled on clk
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_si,
    output reg         spi_so,
    output reg         spi_so_oe_n,
    // operation report toward the array
    output reg         op_start,
    output reg  [2:0]  op_kind,
    output reg  [23:0] op_addr,
    output reg         op_done,
    // state
    output wire        busy,
    output wire        write_en,
    output wire        sleeping,
    output wire [7:0]  status
);

    localparam [31:0] DP_CYCLES  = `SFS_DP_TIME_US * `SFS_CLK_MHZ;
    localparam [31:0] PRB_CYCLES = `SFS_PRB_TIME_US * `SFS_CLK_MHZ;

    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_BUSY     = 3'h1;
    localparam [2:0] ST_PD_ENTER = 3'h2;
    localparam [2:0] ST_PD       = 3'h3;
    localparam [2:0] ST_PD_EXIT  = 3'h4;

    reg  [2:0]  state_r;
    reg  [31:0] timer_r;
    reg         sck_r;
    reg         cs_n_r;
    reg  [2:0]  bit_r;
    reg  [3:0]  byte_r;
    reg  [7:0]  shift_r;
    reg  [7:0]  opcode_r;
    reg  [23:0] addr_r;
    reg  [7:0]  wrsr_r;
    reg         wel_r;
    reg  [7:0]  prot_r;
    reg  [7:0]  so_shift_r;

    wire sck_rise = spi_sck & ~sck_r & ~spi_cs_n;
    wire sck_fall = ~spi_sck & sck_r & ~spi_cs_n;
    wire cs_fall  = ~spi_cs_n & cs_n_r;
    wire cs_rise  = spi_cs_n & ~cs_n_r;
    wire [7:0] next_byte = {shift_r[6:0], spi_si};
    wire byte_done = sck_rise & (bit_r == 3'h7);
    // a write command only counts if chip select rises on a byte boundary
    wire framed  = cs_rise & (bit_r == 3'h0);
    wire is_sse  = (opcode_r == `SFS_OP_SBLK_ER_A) | (opcode_r == `SFS_OP_SBLK_ER_B);
    wire is_se   = (opcode_r == `SFS_OP_BLK_ER);
    wire is_che  = (opcode_r == `SFS_OP_CHIP_ER_A) | (opcode_r == `SFS_OP_CHIP_ER_B);
    wire erase_ok = framed & wel_r & (is_sse | is_se)
                    & (byte_r == `SFS_ERASE_LEN);
    wire che_ok  = framed & wel_r & is_che & (byte_r == 4'h1);
    wire pp_ok   = framed & wel_r & (opcode_r == `SFS_OP_PP)
                    & (byte_r >= `SFS_PP_MIN_LEN);
    wire wrsr_ok = framed & wel_r & (opcode_r == `SFS_OP_WRSR)
                    & (byte_r == `SFS_WRSR_LEN);
    wire one_byte = framed & (byte_r == 4'h1);
    wire ready   = (state_r == ST_IDLE);

    assign busy     = (state_r == ST_BUSY);
    assign write_en = wel_r;
    assign sleeping = (state_r == ST_PD) | (state_r == ST_PD_EXIT);
    assign status   = {prot_r[`SFS_ST_PROT_HI:`SFS_ST_PROT_LO], wel_r, busy};

    // serial front end: bytes shift in msb first on sck rising edges
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_r    <= 1'b0;
            cs_n_r   <= 1'b1;
            bit_r    <= 3'h0;
            byte_r   <= 4'h0;
            shift_r  <= 8'h00;
            opcode_r <= 8'h00;
            addr_r   <= 24'h000000;
            wrsr_r   <= 8'h00;
        end else begin
            sck_r  <= spi_sck;
            cs_n_r <= spi_cs_n;
            if (cs_fall) begin
                bit_r  <= 3'h0;
                byte_r <= 4'h0;
            end else if (sck_rise) begin
                bit_r   <= bit_r + 3'h1;
                shift_r <= next_byte;
                if (byte_done) begin
                    // saturate so long program bursts keep their count valid
                    if (byte_r != 4'hF)
                        byte_r <= byte_r + 4'h1;
                    if (byte_r == 4'h0)
                        opcode_r <= next_byte;
                    if (byte_r >= 4'h1 && byte_r <= `SFS_ADDR_BYTES)
                        addr_r <= {addr_r[15:0], next_byte};
                    if (byte_r == 4'h1)
                        wrsr_r <= next_byte;
                end
            end
        end
    end

    // status read-out: reloaded every byte so polling sees fresh busy
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            spi_so      <= 1'b0;
            spi_so_oe_n <= 1'b1;
            so_shift_r  <= 8'h00;
        end else if (spi_cs_n) begin
            spi_so_oe_n <= 1'b1;
        end else if (byte_done) begin
            so_shift_r <= status;
        end else if (sck_fall && opcode_r == `SFS_OP_RDSR && byte_r != 4'h0) begin
            spi_so      <= so_shift_r[7];
            spi_so_oe_n <= 1'b0;
            so_shift_r  <= {so_shift_r[6:0], 1'b0};
        end
    end

    // operation sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r  <= ST_IDLE;
            timer_r  <= 32'h00000000;
            wel_r    <= 1'b0;
            prot_r   <= `SFS_ST_RESET;
            op_start <= 1'b0;
            op_kind  <= `SFS_KIND_WRSR;
            op_addr  <= 24'h000000;
            op_done  <= 1'b0;
        end else begin
            op_start <= 1'b0;
            op_done  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (one_byte && opcode_r == `SFS_OP_WREN)
                        wel_r <= 1'b1;
                    else if (one_byte && opcode_r == `SFS_OP_WRDI)
                        wel_r <= 1'b0;
                    if (erase_ok) begin
                        state_r  <= ST_BUSY;
                        op_start <= 1'b1;
                        op_addr  <= addr_r;
                        op_kind  <= is_se ? `SFS_KIND_SE : `SFS_KIND_SSE;
                        timer_r  <= is_se ? SE_CYCLES : SSE_CYCLES;
                    end else if (che_ok) begin
                        state_r  <= ST_BUSY;
                        op_start <= 1'b1;
                        op_kind  <= `SFS_KIND_CHE;
                        timer_r  <= CHE_CYCLES;
                    end else if (pp_ok) begin
                        state_r  <= ST_BUSY;
                        op_start <= 1'b1;
                        op_addr  <= addr_r;
                        op_kind  <= `SFS_KIND_PP;
                        timer_r  <= PP_CYCLES;
                    end else if (wrsr_ok) begin
                        state_r  <= ST_BUSY;
                        op_start <= 1'b1;
                        op_kind  <= `SFS_KIND_WRSR;
                        timer_r  <= SRW_CYCLES;
                        prot_r   <= {wrsr_r[`SFS_ST_PROT_HI:`SFS_ST_PROT_LO], 2'b00};
                    end else if (one_byte && opcode_r == `SFS_OP_SLEEP) begin
                        state_r <= ST_PD_ENTER;
                        timer_r <= DP_CYCLES;
                    end
                end
                ST_BUSY: begin
                    if (timer_r <= 32'h00000001) begin
                        state_r <= ST_IDLE;
                        wel_r   <= 1'b0;
                        op_done <= 1'b1;
                    end else begin
                        timer_r <= timer_r - 32'h00000001;
                    end
                end
                ST_PD_ENTER, ST_PD_EXIT: begin
                    if (timer_r <= 32'h00000001)
                        state_r <= (state_r == ST_PD_ENTER) ? ST_PD : ST_IDLE;
                    else
                        timer_r <= timer_r - 32'h00000001;
                end
                ST_PD: begin
                    // only the wake command and RDSR are heard while asleep
                    if (one_byte && opcode_r == `SFS_OP_WAKE) begin
                        state_r <= ST_PD_EXIT;
                        timer_r <= PRB_CYCLES;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// >>> common/sfs_map.vh
`ifndef SFS_MAP_VH
`define SFS_MAP_VH

// opcodes
`define SFS_OP_WREN      8'h06
`define SFS_OP_WRDI      8'h04
`define SFS_OP_RDSR      8'h05
`define SFS_OP_WRSR      8'h01
`define SFS_OP_PP        8'h02
`define SFS_OP_BLK_ER    8'hD8
`define SFS_OP_SBLK_ER_A 8'hD7
`define SFS_OP_SBLK_ER_B 8'h20
`define SFS_OP_CHIP_ER_A 8'hC7
`define SFS_OP_CHIP_ER_B 8'h60
`define SFS_OP_SLEEP     8'hB9
`define SFS_OP_WAKE      8'hAB

// status register fields
`define SFS_ST_BUSY      0
`define SFS_ST_WEL       1
`define SFS_ST_PROT_LO   2
`define SFS_ST_PROT_HI   7
`define SFS_ST_RESET     8'h00

// command framing, in bytes
`define SFS_ADDR_BYTES   3
`define SFS_ERASE_LEN    4
`define SFS_WRSR_LEN     2
`define SFS_PP_MIN_LEN   5

// timing figures and clock rate
`define SFS_CLK_MHZ      250
`define SFS_SRW_TIME_MS  5
`define SFS_PP_TIME_US   4000
`define SFS_SSE_TIME_MS  40
`define SFS_SE_TIME_MS   80
`define SFS_CHE_TIME_MS  250
`define SFS_DP_TIME_US   3
`define SFS_PRB_TIME_US  3

// operation kinds reported with op_start
`define SFS_KIND_WRSR    3'h0
`define SFS_KIND_PP      3'h1
`define SFS_KIND_SSE     3'h2
`define SFS_KIND_SE      3'h3
`define SFS_KIND_CHE     3'h4

`endif

// >>> dv/sfs_seq_assertions.sv
`timescale 1ns/1ps
`include "sfs_map.vh"
module sfs_seq_assertions #(
    parameter [31:0] SRW_CYCLES = 32'h1,
    parameter [31:0] PP_CYCLES  = 32'h1,
    parameter [31:0] SSE_CYCLES = 32'h1,
    parameter [31:0] SE_CYCLES  = 32'h1,
    parameter [31:0] CHE_CYCLES = 32'h1
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       spi_cs_n,
    input wire logic       op_start,
    input wire logic [2:0] op_kind,
    input wire logic       op_done,
    input wire logic       busy,
    input wire logic       write_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // busy cycles since the last start, equals the duration at op_done
    logic [31:0] cnt_r;
    logic [2:0]  kind_r;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 32'h0;
            kind_r <= 3'h0;
        end else if (op_start) begin
            cnt_r <= 32'h1;
            kind_r <= op_kind;
        end else if (busy) begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
    property p_cs_start; op_start |-> $past(spi_cs_n) && !$past(spi_cs_n, 2); endproperty
    a_cs_start: assert property (p_cs_start) else $error("start without cs rise");
    property p_busy_rise; $rose(busy) |-> op_start; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
    property p_done_clear; op_done |-> $past(busy) && !busy && !write_en; endproperty
    a_done_clear: assert property (p_done_clear) else $error("done state wrong");
    property p_srw; op_done && kind_r == `SFS_KIND_WRSR |-> cnt_r == SRW_CYCLES; endproperty
    a_srw: assert property (p_srw) else $error("status write time");
    property p_pp; op_done && kind_r == `SFS_KIND_PP |-> cnt_r == PP_CYCLES; endproperty
    a_pp: assert property (p_pp) else $error("program time");
    property p_sse; op_done && kind_r == `SFS_KIND_SSE |-> cnt_r == SSE_CYCLES; endproperty
    a_sse: assert property (p_sse) else $error("small erase time");
    property p_se; op_done && kind_r == `SFS_KIND_SE |-> cnt_r == SE_CYCLES; endproperty
    a_se: assert property (p_se) else $error("sector erase time");
    property p_che; op_done && kind_r == `SFS_KIND_CHE |-> cnt_r == CHE_CYCLES; endproperty
    a_che: assert property (p_che) else $error("chip erase time");
endmodule
bind sfs_seq sfs_seq_assertions #(.SRW_CYCLES(SRW_CYCLES), .PP_CYCLES(PP_CYCLES),
    .SSE_CYCLES(SSE_CYCLES), .SE_CYCLES(SE_CYCLES), .CHE_CYCLES(CHE_CYCLES)) i_chk (
    .clk(clk), .reset(reset), .spi_cs_n(spi_cs_n), .op_start(op_start), .op_kind(op_kind),
    .op_done(op_done), .busy(busy), .write_en(write_en));

// >>> dv/sfs_host.sv
`timescale 1ns/1ps
module sfs_host (
    input  wire logic clk,
    input  wire logic so,
    output logic      sck,
    output logic      cs_n,
    output logic      si
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // sck stands low between frames; two clk per phase as the sampler needs
    task automatic frame(input logic [39:0] w, input int nb, output logic [7:0] rd);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            si = w[39 - i];
            repeat (2) @(negedge clk);
            rd = {rd[6:0], so};
            sck = 1'b1;
            repeat (2) @(negedge clk);
            sck = 1'b0;
        end
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (4) @(negedge clk);
    endtask
endmodule

// >>> dv/sfs_seq_tb.sv
`timescale 1ns/1ps
`include "sfs_map.vh"
module sfs_seq_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    wire         sck, cs_n, si, so, so_oe_n, op_start, op_done, busy, write_en, sleeping;
    wire  [2:0]  op_kind;
    wire  [23:0] op_addr;
    wire  [7:0]  status;
    int          err_count = 0, checks_done = 0, starts = 0, dones = 0, oe_low = 0;
    logic [2:0]  kind_s;
    logic [23:0] addr_s;
    logic [7:0]  rd;
    always #2 clk = ~clk;
    sfs_seq #(.SRW_CYCLES(200), .PP_CYCLES(250), .SSE_CYCLES(300), .SE_CYCLES(350),
        .CHE_CYCLES(400)) i_dut (.clk(clk), .reset(reset), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_si(si), .spi_so(so), .spi_so_oe_n(so_oe_n), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .busy(busy),
        .write_en(write_en),
        .sleeping(sleeping), .status(status));
    sfs_host i_host (.clk(clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));
    always @(posedge clk) begin
        if (op_start) begin
            starts++;
            kind_s = op_kind;
            addr_s = op_addr;
        end
        if (op_done) dones++;
        if (!so_oe_n) oe_low++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmd(input logic [39:0] w, input int nb);
        i_host.frame(w, nb, rd);
    endtask
    task automatic run_op(input logic [39:0] w, input int nb, input logic [2:0] k);
        int s0, o0;
        s0 = starts;
        cmd({`SFS_OP_WREN, 32'h0}, 1);
        cmd(w, nb);
        chk("start", starts, s0 + 1);
        chk("kind", kind_s, k);
        if (nb > 2) chk("addr", addr_s, w[31:8]);
        chk("status busy", status[1:0], 2'h3);
        o0 = oe_low;
        cmd({`SFS_OP_RDSR, 32'h0}, 2);
        chk("busy bits", rd[1:0], 2'h3);
        chk("oe drive", oe_low > o0, 1'b1);
        chk("oe idle", so_oe_n, 1'b1);
        for (int i = 0; i < 20 && rd[0] !== 1'b0; i++) cmd({`SFS_OP_RDSR, 32'h0}, 2);
        chk("done", dones, s0 + 1);
        chk("wel", write_en, 1'b0);
    endtask
    task automatic t_sector;
        run_op({`SFS_OP_BLK_ER, 24'h12_3456, 8'h00}, 4, `SFS_KIND_SE);
        $display("test sector erase done");
    endtask
    task automatic t_small;
        run_op({`SFS_OP_SBLK_ER_A, 24'hFE_DCBA, 8'h00}, 4, `SFS_KIND_SSE);
        run_op({`SFS_OP_SBLK_ER_B, 24'h00_1000, 8'h00}, 4, `SFS_KIND_SSE);
        $display("test small erase done");
    endtask
    task automatic t_chip_prog;
        run_op({`SFS_OP_CHIP_ER_A, 32'h0}, 1, `SFS_KIND_CHE);
        run_op({`SFS_OP_PP, 24'h03_0100, 8'hA5}, 5, `SFS_KIND_PP);
        $display("test chip erase and program done");
    endtask
    task automatic t_refused;
        int s0, o0;
        s0 = starts;
        o0 = oe_low;
        cmd({`SFS_OP_BLK_ER, 24'h01_0000, 8'h00}, 4);
        chk("no wel erase", starts, s0);
        chk("quiet so", oe_low, o0);
        cmd({`SFS_OP_WREN, 32'h0}, 1);
        cmd({`SFS_OP_BLK_ER, 24'h01_0000, 8'h00}, 3);
        chk("short erase", starts, s0);
        chk("wren kept", write_en, 1'b1);
        cmd({`SFS_OP_WRDI, 32'h0}, 1);
        chk("wrdi", write_en, 1'b0);
        cmd({`SFS_OP_BLK_ER, 24'h01_0000, 8'h00}, 4);
        chk("erase after wrdi", starts, s0);
        $display("test refused done");
    endtask
    task automatic t_sleep;
        cmd({`SFS_OP_SLEEP, 32'h0}, 1);
        repeat (750) @(negedge clk);
        chk("asleep", sleeping, 1'b1);
        cmd({`SFS_OP_WREN, 32'h0}, 1);
        chk("asleep wren", write_en, 1'b0);
        cmd({`SFS_OP_WAKE, 32'h0}, 1);
        repeat (750) @(negedge clk);
        chk("awake", sleeping, 1'b0);
        $display("test sleep done");
    endtask
    task automatic t_wrsr;
        run_op({`SFS_OP_WRSR, 8'h3C, 24'h0}, 2, `SFS_KIND_WRSR);
        chk("status", rd, 8'h3C);
        chk("status port", status, 8'h3C);
        $display("test status write done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_sector();
        t_small();
        t_chip_prog();
        t_refused();
        t_sleep();
        t_wrsr();
        complete_run();
    end
    // about 5k cycles expected; allow about ten times that before giving up
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule
